// ### bus_matrix_pkg.sv
package bus_matrix_pkg;

	localparam int NUM_MASTERS = 5;
	localparam int NUM_SLAVES  = 5;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	localparam int IDX_W       = 3;
	localparam int SLOT_W      = 8;

	// master port numbers
	localparam logic [IDX_W-1:0] MST_INSTR = 3'h0;
	localparam logic [IDX_W-1:0] MST_DATA  = 3'h1;
	localparam logic [IDX_W-1:0] MST_DMA   = 3'h2;
	localparam logic [IDX_W-1:0] MST_LCD   = 3'h3;
	localparam logic [IDX_W-1:0] MST_USB   = 3'h4;

	// slave port numbers
	localparam logic [IDX_W-1:0] SLV_SRAM   = 3'h0;
	localparam logic [IDX_W-1:0] SLV_ROM    = 3'h1;
	localparam logic [IDX_W-1:0] SLV_HOSTIF = 3'h2;
	localparam logic [IDX_W-1:0] SLV_EXT    = 3'h3;
	localparam logic [IDX_W-1:0] SLV_PERIPH = 3'h4;

	// first-level decode: top four address bits
	localparam int REGION_MSB = 31;
	localparam int REGION_LSB = 28;
	localparam logic [3:0] REGION_INTERNAL = 4'h0;
	localparam logic [3:0] REGION_EXT_FIRST = 4'h1;
	localparam logic [3:0] REGION_EXT_LAST  = 4'h8;
	localparam logic [3:0] REGION_PERIPH    = 4'hf;

	// second-level decode: 1 Mbyte windows inside region zero
	localparam int WIN_MSB = 27;
	localparam int WIN_LSB = 20;
	localparam logic [7:0] WIN_BOOT   = 8'h00;
	localparam logic [7:0] WIN_SRAM_A = 8'h01;
	localparam logic [7:0] WIN_SRAM_B = 8'h02;
	localparam logic [7:0] WIN_SRAM_C = 8'h03;
	localparam logic [7:0] WIN_ROM    = 8'h04;
	localparam logic [7:0] WIN_UHP    = 8'h05;
	localparam logic [7:0] WIN_LCD    = 8'h06;
	localparam logic [11:0] SRAM_C_PAGE = 12'h003;

	// transfer sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// default-master policies
	localparam logic [1:0] DEF_NONE  = 2'h0;
	localparam logic [1:0] DEF_LAST  = 2'h1;
	localparam logic [1:0] DEF_FIXED = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_DONE = 3'b010,
		ST_ERR1 = 3'b011,
		ST_ERR2 = 3'b100
	} mst_state_t;

	typedef struct packed {
		logic              valid;
		logic [IDX_W-1:0]  slave;
		logic [2:0]        cs;
		logic [ADDR_W-1:0] addr;
	} dec_t;

endpackage : bus_matrix_pkg

// ### slave_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module slave_arbiter #(
	parameter int N      = bus_matrix_pkg::NUM_MASTERS,
	parameter int SLOT_W = bus_matrix_pkg::SLOT_W
) (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic [N-1:0]                     req,
	input  wire logic [N-1:0]                     hold,
	input  wire logic                             busy,
	input  wire logic [1:0]                       policy,
	input  wire logic [bus_matrix_pkg::IDX_W-1:0] fixed_master,
	input  wire logic [SLOT_W-1:0]                slot_limit,
	output logic [bus_matrix_pkg::IDX_W-1:0]      owner,
	output logic                                  owned
);
	import bus_matrix_pkg::*;

	logic [IDX_W-1:0]  last;
	logic [SLOT_W-1:0] slot_cnt;
	logic [IDX_W-1:0]  pick;
	logic              others;
	logic              keep;

	// search starts just after the last winner
	always_comb begin
		int j;
		j = 0;
		pick = last;
		for (int i = N; i >= 1; i--) begin
			j = (int'(last) + i) % N;
			if (req[j])
				pick = IDX_W'(j);
		end
	end

	always_comb begin
		others = 1'b0;
		for (int i = 0; i < N; i++)
			if (req[i] && IDX_W'(i) != owner)
				others = 1'b1;
	end

	// zero slot limit means bursts are never broken
	assign keep = owned && (req[owner] || hold[owner])
		&& !(slot_limit != '0 && slot_cnt >= slot_limit && others);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			owner    <= '0;
			owned    <= 1'b0;
			last     <= '0;
			slot_cnt <= '0;
		end else if (busy || keep) begin
			if (slot_cnt != {SLOT_W{1'b1}})
				slot_cnt <= slot_cnt + 1'b1;
		end else if (|req) begin
			owner    <= pick;
			owned    <= 1'b1;
			last     <= pick;
			slot_cnt <= '0;
		end else begin
			slot_cnt <= '0;
			unique case (policy)
				DEF_LAST:  owned <= 1'b1;
				DEF_FIXED: begin
					owner <= fixed_master;
					owned <= 1'b1;
				end
				default:   owned <= 1'b0;
			endcase
		end
	end

endmodule : slave_arbiter
`default_nettype wire

// ### system_bus_matrix_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module system_bus_matrix_decoder #(
	parameter int NM     = bus_matrix_pkg::NUM_MASTERS,
	parameter int NS     = bus_matrix_pkg::NUM_SLAVES,
	parameter int SLOT_W = bus_matrix_pkg::SLOT_W
) (
	input  wire logic                                         CLK_SYS,
	input  wire logic                                         RST,
	input  wire logic                                         BOOT_SOURCE_SELECT,
	input  wire logic                                         SWAP_CTRL_INSTR_MASTER,
	input  wire logic                                         SWAP_CTRL_DATA_MASTER,
	input  wire logic [NS-1:0][1:0]                           ARB_POLICY,
	input  wire logic [NS-1:0][bus_matrix_pkg::IDX_W-1:0]     ARB_FIXED_MASTER,
	input  wire logic [NS-1:0][SLOT_W-1:0]                    ARB_SLOT_LIMIT,
	input  wire logic [NM-1:0]                                M_REQ,
	input  wire logic [NM-1:0][bus_matrix_pkg::ADDR_W-1:0]    M_ADDR,
	input  wire logic [NM-1:0]                                M_WRITE,
	input  wire logic [NM-1:0][1:0]                           M_SIZE,
	input  wire logic [NM-1:0]                                M_BURST,
	input  wire logic [NM-1:0][bus_matrix_pkg::DATA_W-1:0]    M_WDATA,
	output logic [NM-1:0]                                     M_READY,
	output logic [NM-1:0]                                     M_ERROR,
	output logic [NM-1:0][bus_matrix_pkg::DATA_W-1:0]         M_RDATA,
	output logic [NS-1:0]                                     S_SEL,
	output logic [NS-1:0][bus_matrix_pkg::ADDR_W-1:0]         S_ADDR,
	output logic [NS-1:0]                                     S_WRITE,
	output logic [NS-1:0][1:0]                                S_SIZE,
	output logic [NS-1:0][bus_matrix_pkg::DATA_W-1:0]         S_WDATA,
	output logic [NS-1:0][bus_matrix_pkg::IDX_W-1:0]          S_MASTER,
	input  wire logic [NS-1:0][bus_matrix_pkg::DATA_W-1:0]    S_RDATA,
	input  wire logic [NS-1:0]                                S_READY,
	output logic [7:0]                                        EXT_CHIP_SELECT,
	output logic                                              BOOT_INTERNAL
);
	import bus_matrix_pkg::*;

	mst_state_t               state    [NM];
	logic [NM-1:0][ADDR_W-1:0] xfer_addr;
	logic [NM-1:0][IDX_W-1:0]  xfer_slave;
	logic [NM-1:0][2:0]        xfer_cs;
	logic [NM-1:0]             xfer_write;
	logic [NM-1:0][1:0]        xfer_size;
	logic [NM-1:0][DATA_W-1:0] xfer_wdata;
	logic [NM-1:0]             burst;
	logic [NM-1:0][DATA_W-1:0] rdata;
	logic                      boot_internal;
	logic                      boot_taken;
	logic [NM-1:0]             swap;
	dec_t                      dec      [NM];
	logic [NS-1:0][NM-1:0]     slv_req;
	logic [NS-1:0][IDX_W-1:0]  owner;
	logic [NS-1:0]             owned;
	logic [NS-1:0]             sel;
	logic [NS-1:0]             slv_done;
	logic [NS-1:0]             busy;
	logic [NM-1:0]             m_done;
	logic [NM-1:0][IDX_W-1:0]  grant_slave;

	function automatic logic is_cpu(input int m);
		is_cpu = (IDX_W'(m) == MST_INSTR) || (IDX_W'(m) == MST_DATA);
	endfunction : is_cpu

	function automatic logic size_ok(input logic [1:0] sz);
		size_ok = (sz == SIZE_BYTE) || (sz == SIZE_HALF) || (sz == SIZE_WORD);
	endfunction : size_ok

	// per-master address decoder; the mapping depends on the master identity
	function automatic dec_t decode_addr(
		input logic [ADDR_W-1:0] a,
		input logic              cpu,
		input logic              swapped,
		input logic              boot_int
	);
		dec_t       d;
		logic [3:0] region;
		logic [7:0] win;
		d      = '0;
		region = a[REGION_MSB:REGION_LSB];
		win    = a[WIN_MSB:WIN_LSB];
		d.addr = a;
		if (region == REGION_INTERNAL) begin
			d.valid = 1'b1;
			unique case (win)
				WIN_BOOT: begin
					if (cpu && swapped) begin
						d.slave = SLV_SRAM;
						d.addr  = {SRAM_C_PAGE, a[WIN_LSB-1:0]};
					end else if (boot_int) begin
						d.slave = SLV_ROM;
					end else begin
						d.slave = SLV_EXT;
						d.cs    = 3'h0;
					end
				end
				WIN_SRAM_A, WIN_SRAM_B, WIN_SRAM_C: d.slave = SLV_SRAM;
				WIN_ROM:                            d.slave = SLV_ROM;
				WIN_UHP, WIN_LCD:                   d.slave = SLV_HOSTIF;
				default:                            d.valid = 1'b0;
			endcase
		end else if (region >= REGION_EXT_FIRST && region <= REGION_EXT_LAST) begin
			d.valid = 1'b1;
			d.slave = SLV_EXT;
			d.cs    = 3'(region - REGION_EXT_FIRST);
		end else if (region == REGION_PERIPH) begin
			d.valid = 1'b1;
			d.slave = SLV_PERIPH;
		end
		decode_addr = d;
	endfunction : decode_addr

	// the strap is caught on the first clock after reset, then frozen
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			boot_internal <= 1'b0;
			boot_taken    <= 1'b0;
		end else if (!boot_taken) begin
			boot_internal <= BOOT_SOURCE_SELECT;
			boot_taken    <= 1'b1;
		end
	end

	assign BOOT_INTERNAL = boot_internal;

	// only the two processor masters see a swap bit
	always_comb begin
		swap = '0;
		swap[MST_INSTR] = SWAP_CTRL_INSTR_MASTER;
		swap[MST_DATA]  = SWAP_CTRL_DATA_MASTER;
	end

	// one decoder per master, evaluated on the live request
	always_comb begin
		for (int m = 0; m < NM; m++)
			dec[m] = decode_addr(M_ADDR[m], is_cpu(m), swap[m], boot_internal);
	end

	// which slave each master is granted on, if any
	always_comb begin
		grant_slave = '0;
		m_done      = '0;
		for (int s = 0; s < NS; s++) begin
			if (sel[s]) begin
				grant_slave[owner[s]] = IDX_W'(s);
				if (slv_done[s])
					m_done[owner[s]] = 1'b1;
			end
		end
	end

	// master-side sequencing; decode is frozen when the request is taken
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			for (int m = 0; m < NM; m++)
				state[m] <= ST_IDLE;
			xfer_addr  <= '0;
			xfer_slave <= '0;
			xfer_cs    <= '0;
			xfer_write <= '0;
			xfer_size  <= '0;
			xfer_wdata <= '0;
		end else begin
			for (int m = 0; m < NM; m++) begin
				unique case (state[m])
					ST_IDLE: begin
						if (M_REQ[m] && boot_taken) begin
							xfer_addr[m]  <= dec[m].addr;
							xfer_slave[m] <= dec[m].slave;
							xfer_cs[m]    <= dec[m].cs;
							xfer_write[m] <= M_WRITE[m];
							xfer_size[m]  <= M_SIZE[m];
							xfer_wdata[m] <= M_WDATA[m];
							if (dec[m].valid && size_ok(M_SIZE[m]))
								state[m] <= ST_WAIT;
							else
								state[m] <= ST_ERR1;
						end
					end
					ST_WAIT: begin
						if (m_done[m])
							state[m] <= ST_DONE;
					end
					ST_DONE: state[m] <= ST_IDLE;
					ST_ERR1: state[m] <= ST_ERR2;
					ST_ERR2: state[m] <= ST_IDLE;
					default: state[m] <= ST_IDLE;
				endcase
			end
		end
	end

	// burst intent lets the owner keep the slave between beats
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			burst <= '0;
		end else begin
			for (int m = 0; m < NM; m++) begin
				if (state[m] == ST_IDLE && M_REQ[m])
					burst[m] <= M_BURST[m];
				else if (state[m] == ST_IDLE && !M_REQ[m])
					burst[m] <= 1'b0;
			end
		end
	end

	// read data captured on completion so it comes from a flop
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata <= '0;
		end else begin
			for (int m = 0; m < NM; m++)
				if (m_done[m] && !xfer_write[m])
					rdata[m] <= S_RDATA[grant_slave[m]];
		end
	end

	always_comb begin
		for (int m = 0; m < NM; m++) begin
			M_READY[m] = (state[m] == ST_DONE) || (state[m] == ST_ERR2);
			M_ERROR[m] = (state[m] == ST_ERR1) || (state[m] == ST_ERR2);
		end
	end

	assign M_RDATA = rdata;

	// request vectors seen by each slave arbiter
	always_comb begin
		slv_req = '0;
		for (int s = 0; s < NS; s++)
			for (int m = 0; m < NM; m++)
				slv_req[s][m] = (state[m] == ST_WAIT) && (xfer_slave[m] == IDX_W'(s));
	end

	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_slave
			slave_arbiter #(
				.N      (NM),
				.SLOT_W (SLOT_W)
			) u_arb (
				.clk          (CLK_SYS),
				.rst          (RST),
				.req          (slv_req[gs]),
				.hold         (burst),
				.busy         (busy[gs]),
				.policy       (ARB_POLICY[gs]),
				.fixed_master (ARB_FIXED_MASTER[gs]),
				.slot_limit   (ARB_SLOT_LIMIT[gs]),
				.owner        (owner[gs]),
				.owned        (owned[gs])
			);
		end
	endgenerate

	// a parked default master gets its select in the same cycle
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			sel[s] = owned[s] && slv_req[s][owner[s]];
			if (IDX_W'(s) == SLV_SRAM || IDX_W'(s) == SLV_ROM)
				slv_done[s] = sel[s];
			else
				slv_done[s] = sel[s] && S_READY[s];
			busy[s] = sel[s] && !slv_done[s];
		end
	end

	// slave-side fan-out of the owner's latched transfer
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			S_SEL[s]    = sel[s];
			S_ADDR[s]   = xfer_addr[owner[s]];
			S_WRITE[s]  = xfer_write[owner[s]];
			S_SIZE[s]   = xfer_size[owner[s]];
			S_WDATA[s]  = xfer_wdata[owner[s]];
			S_MASTER[s] = owner[s];
		end
	end

	// chip select for the external slave; cs0 may host the 16-bit boot device
	always_comb begin
		EXT_CHIP_SELECT = '0;
		if (sel[SLV_EXT])
			EXT_CHIP_SELECT[xfer_cs[owner[SLV_EXT]]] = 1'b1;
	end

endmodule : system_bus_matrix_decoder
`default_nettype wire

// ### system_bus_matrix_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module system_bus_matrix_decoder_asserts #(
	parameter int NM = bus_matrix_pkg::NUM_MASTERS,
	parameter int NS = bus_matrix_pkg::NUM_SLAVES
) (
	input wire logic					CLK_SYS,
	input wire logic					RST,
	input wire logic					BOOT_SOURCE_SELECT,
	input wire logic [NM-1:0]				M_REQ,
	input wire logic [NM-1:0][bus_matrix_pkg::ADDR_W-1:0]	M_ADDR,
	input wire logic [NM-1:0]				M_READY,
	input wire logic [NM-1:0]				M_ERROR,
	input wire logic [NS-1:0]				S_SEL,
	input wire logic [NS-1:0][bus_matrix_pkg::ADDR_W-1:0]	S_ADDR,
	input wire logic [NS-1:0][bus_matrix_pkg::IDX_W-1:0]	S_MASTER,
	input wire logic [NS-1:0]				S_READY,
	input wire logic [7:0]					EXT_CHIP_SELECT,
	input wire logic					BOOT_INTERNAL
);
	import bus_matrix_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// two error cycles, completion rides the second
	sequence s_abort;
		M_ERROR[2] ##1 (M_ERROR[2] && M_READY[2]);
	endsequence
	// owning master sees completion; select drops or passes straight to a new owner
	sequence s_release(int s);
		M_READY[$past(S_MASTER[s])] && (!S_SEL[s] || S_MASTER[s] != $past(S_MASTER[s]));
	endsequence
	a_abort_two: assert property ($rose(M_REQ[2]) && M_ADDR[2][31:28] == 4'h9 |=> s_abort)
		else $error("abort response wrong");
	a_sram_fast: assert property (S_SEL[0] |=> s_release(0))
		else $error("sram access not single cycle");
	a_rom_fast: assert property (S_SEL[1] |=> s_release(1))
		else $error("rom access not single cycle");
	a_ext_done: assert property (S_SEL[3] && S_READY[3] |=> s_release(3))
		else $error("ext completion not passed on");
	a_cs_match: assert property (EXT_CHIP_SELECT == (!S_SEL[3] ? 8'h00 :
			(S_ADDR[3][31:28] == 4'h0) ? 8'h01 : 8'h01 << (S_ADDR[3][31:28] - 4'h1)))
		else $error("chip select wrong");
	a_periph_route: assert property (S_SEL[4] |-> S_ADDR[4][31:28] == 4'hf)
		else $error("peripheral slave outside region 15");
	a_sram_window: assert property (S_SEL[0] |-> S_ADDR[0][31:22] == 10'h000 &&
			S_ADDR[0][21:20] != 2'h0)
		else $error("sram address outside its windows");
	a_boot_rom: assert property (S_SEL[1] && S_ADDR[1][31:20] == 12'h000 |-> BOOT_INTERNAL)
		else $error("rom boot area without internal strap");
	a_boot_ext: assert property (S_SEL[3] && S_ADDR[3][31:28] == 4'h0 |-> !BOOT_INTERNAL)
		else $error("ext boot area with internal strap");
	a_strap_take: assert property ($fell(RST) |=> BOOT_INTERNAL == $past(BOOT_SOURCE_SELECT))
		else $error("strap not captured");
	a_strap_hold: assert property (!$fell(RST) |=> $stable(BOOT_INTERNAL))
		else $error("captured strap changed");
endmodule : system_bus_matrix_decoder_asserts
bind system_bus_matrix_decoder system_bus_matrix_decoder_asserts #(.NM(NM), .NS(NS)) i_asserts (
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.BOOT_SOURCE_SELECT(BOOT_SOURCE_SELECT),
	.M_REQ(M_REQ),
	.M_ADDR(M_ADDR),
	.M_READY(M_READY),
	.M_ERROR(M_ERROR),
	.S_SEL(S_SEL),
	.S_ADDR(S_ADDR),
	.S_MASTER(S_MASTER),
	.S_READY(S_READY),
	.EXT_CHIP_SELECT(EXT_CHIP_SELECT),
	.BOOT_INTERNAL(BOOT_INTERNAL)
);
`default_nettype wire

// ### slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module slave_model (
	input wire logic		clk,
	input wire logic		rst,
	input wire logic [3:0]		dly,
	input wire logic [4:0]		sel,
	input wire logic [4:0][31:0]	addr,
	output logic [4:0][31:0]	rdata,
	output logic [4:0]		ready
);
	logic [4:0][3:0]	cnt;
	logic [31:0]		tick;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			tick <= '0;
		end else begin
			tick <= tick + 32'h1;
			for (int s = 0; s < 5; s++) begin
				cnt[s] <= sel[s] ? cnt[s] + 4'h1 : 4'h0;
			end
		end
	end
	// idle data keeps moving so a stale word never passes for a read
	always_comb begin
		for (int s = 0; s < 5; s++) begin
			rdata[s] = sel[s] ? addr[s] + 32'(s) : tick;
			ready[s] = sel[s] && cnt[s] >= dly;
		end
		if (sel[3]) begin
			rdata[3] = {16'h0000, addr[3][15:0]};
		end
	end
endmodule : slave_model
`default_nettype wire

// ### system_bus_matrix_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module system_bus_matrix_decoder_test;
	import bus_matrix_pkg::*;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	logic			strap = 1'b1;
	logic			swap_i = 1'b0;
	logic			swap_d = 1'b0;
	logic [3:0]		dly = 4'h0;
	logic [4:0]		req = '0;
	logic [4:0][31:0]	addr = '0;
	logic [4:0][1:0]	size = '0;
	logic [4:0]		rdy, err, s_sel, s_ready;
	logic [4:0][31:0]	rdata, s_addr, s_rdata;
	logic			boot;
	int			fails = 0;
	int			num_checks = 0;
	logic [31:0]		amap [6] = '{32'h0010_0004, 32'h0040_0008, 32'h0050_0000,
					32'h1000_0010, 32'h8000_0020, 32'hf000_0030};
	logic [31:0]		dmap [6] = '{32'h0010_0004, 32'h0040_0009, 32'h0050_0002,
					32'h0000_0010, 32'h0000_0020, 32'hf000_0034};
	always #5 clk = ~clk;
	system_bus_matrix_decoder i_system_bus_matrix_decoder (
		.CLK_SYS(clk),
		.RST(rst),
		.BOOT_SOURCE_SELECT(strap),
		.SWAP_CTRL_INSTR_MASTER(swap_i),
		.SWAP_CTRL_DATA_MASTER(swap_d),
		.ARB_POLICY({DEF_LAST, DEF_NONE, DEF_FIXED, DEF_LAST, DEF_NONE}),
		.ARB_FIXED_MASTER({5{3'h2}}),
		.ARB_SLOT_LIMIT({5{8'h02}}),
		.M_REQ(req),
		.M_ADDR(addr),
		.M_WRITE(5'h00),
		.M_SIZE(size),
		.M_BURST(5'h00),
		.M_WDATA('0),
		.M_READY(rdy),
		.M_ERROR(err),
		.M_RDATA(rdata),
		.S_SEL(s_sel),
		.S_ADDR(s_addr),
		.S_WRITE(),
		.S_SIZE(),
		.S_WDATA(),
		.S_MASTER(),
		.S_RDATA(s_rdata),
		.S_READY(s_ready),
		.EXT_CHIP_SELECT(),
		.BOOT_INTERNAL(boot)
	);
	slave_model i_slave_model (
		.clk(clk),
		.rst(rst),
		.dly(dly),
		.sel(s_sel),
		.addr(s_addr),
		.rdata(s_rdata),
		.ready(s_ready)
	);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic do_reset(input logic s);
		rst <= 1'b1;
		strap <= s;
		swap_i <= 1'b0;
		swap_d <= 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("boot strap", {31'h0, s}, {31'h0, boot});
		strap <= ~s;
	endtask : do_reset
	// one beat: hold the request until completion, then let go
	task automatic xfer(input int m, input logic [31:0] a, input logic [1:0] sz,
			input logic e, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req[m] <= 1'b1;
		addr[m] <= a;
		size[m] <= sz;
		do begin
			@(negedge clk);
			n++;
		end while (rdy[m] !== 1'b1 && n < 20);
		if (n == 20) begin
			fails++;
			give_verdict();
		end
		chk("error flag", {31'h0, e}, {31'h0, err[m]});
		if (!e) begin
			chk("read data", d, rdata[m]);
		end
		@(posedge clk);
		req[m] <= 1'b0;
	endtask : xfer
	initial begin
		do_reset(1'b1);
		for (int i = 0; i < 6; i++) begin
			dly <= 4'(i);
			xfer(1, amap[i], 2'(i % 3), 1'b0, dmap[i]);
		end
		$display("test decode done");
		for (int r = 9; r < 15; r++) begin
			xfer(2, {4'(r), 28'h0}, SIZE_WORD, 1'b1, 32'h0);
		end
		xfer(2, 32'h0070_0000, SIZE_WORD, 1'b1, 32'h0);
		xfer(3, 32'h0010_0000, 2'h3, 1'b1, 32'h0);
		$display("test abort done");
		xfer(0, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0000_0101);
		swap_i <= 1'b1;
		xfer(0, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0030_0100);
		xfer(1, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0000_0101);
		xfer(2, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0000_0101);
		xfer(4, 32'h0030_0100, SIZE_WORD, 1'b0, 32'h0030_0100);
		do_reset(1'b0);
		xfer(1, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0000_0100);
		swap_d <= 1'b1;
		xfer(1, 32'h0000_0100, SIZE_WORD, 1'b0, 32'h0030_0100);
		$display("test boot done");
		dly <= 4'h2;
		fork
			xfer(2, 32'h2000_0040, SIZE_WORD, 1'b0, 32'h0000_0040);
			xfer(3, 32'h2000_0080, SIZE_WORD, 1'b0, 32'h0000_0080);
			xfer(4, 32'h0010_0000, SIZE_WORD, 1'b0, 32'h0010_0000);
		join
		$display("test arbitration done");
		give_verdict();
	end
endmodule : system_bus_matrix_decoder_test
`default_nettype wire
